// File: rtl/cdlc_top.sv
// cdlc_top: input capture, channel steering and dac latch control
// for a six-channel column driver. assumes all inputs synchronous to mclk.
//
// Overview of operation
// - video code is ten bits parallel, bit 9 most significant
// - capture on falling edge when phase select low, rising edge when high
// - select 000..101 loads channel 0..5, start/select acts as chip select
// - select 111 loads by sequencer, launched by pulse on start/select
// - sequencer counts 0 up to 5 when direction low, 5 down when high
// - transfer sampled high at rising edge moves staged codes on next fall
// - polarity high gives output above midpoint, low gives below midpoint
// - power-down request high blocks loads, transfers and the sequencer; capture and polarity keep running
// - three-bit select picks input latch together with start/select
// - dac latches are master-slave so all six outputs update together
// - sequenced loading starts on first rising edge after valid start
`timescale 1ns/1ns
`include "cdlc_defines.svh"
module cdlc_top
  import cdlc_pkg::*;
#(
  parameter int NUM_CH = `CDLC_NUM_CH
) (
  input  wire logic [`CDLC_CODE_W-1:0]         video_code_in,
  input  wire logic                            edge_phase_select,
  input  wire logic                            load_direction,
  input  wire logic [`CDLC_SEL_W-1:0]          channel_select,
  input  wire logic                            sequence_start_or_select,
  input  wire logic                            output_transfer_strobe,
  input  wire logic                            polarity_invert,
  input  wire logic                            power_down_request,
  input  wire logic                            mclk,
  input  wire logic                            rst_b,
  output logic [NUM_CH-1:0][`CDLC_CODE_W-1:0]  dac_code,
  output logic [NUM_CH-1:0][`CDLC_CODE_W-1:0]  dac_level,
  output logic                                 polarity_above_mid,
  output logic                                 power_down_active,
  output logic                                 load_overflow
);
  localparam int FW = `CDLC_CODE_W + `CDLC_SEL_W;

  // dual-edge input capture; phase select chooses which copy is used
  cdlc_code_t code_rise_reg;
  cdlc_code_t code_fall_reg;
  cdlc_sel_t  sel_rise_reg;
  cdlc_sel_t  sel_fall_reg;
  logic       cs_rise_reg;
  logic       cs_fall_reg;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      code_rise_reg <= `CDLC_CODE_RST;
      sel_rise_reg  <= '0;
      cs_rise_reg   <= 1'b0;
    end
    else
    begin
      code_rise_reg <= video_code_in;
      sel_rise_reg  <= channel_select;
      cs_rise_reg   <= sequence_start_or_select;
    end
  end

  always_ff @(negedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      code_fall_reg <= `CDLC_CODE_RST;
      sel_fall_reg  <= '0;
      cs_fall_reg   <= 1'b0;
    end
    else
    begin
      code_fall_reg <= video_code_in;
      sel_fall_reg  <= channel_select;
      cs_fall_reg   <= sequence_start_or_select;
    end
  end

  // the selected edge's copy feeds the steering logic in the mclk domain
  wire cdlc_code_t cap_code = edge_phase_select ? code_rise_reg : code_fall_reg;
  wire cdlc_sel_t  cap_sel  = edge_phase_select ? sel_rise_reg : sel_fall_reg;
  wire             cap_cs   = edge_phase_select ? cs_rise_reg : cs_fall_reg;

  // sequencer state
  cdlc_seq_e  seq_state_reg;
  cdlc_seq_e  seq_state_next;
  cdlc_sel_t  seq_ch_reg;
  cdlc_sel_t  seq_ch_next;
  logic       start_prev_reg;
  logic       pd_reg;

  wire seq_mode   = (channel_select == `CDLC_SEL_SEQ);
  wire start_rise = sequence_start_or_select && !start_prev_reg;
  wire cdlc_sel_t seq_first = load_direction ? `CDLC_CH_LAST : `CDLC_CH_FIRST;
  wire cdlc_sel_t seq_end   = load_direction ? `CDLC_CH_FIRST : `CDLC_CH_LAST;
  wire seq_load   = (seq_state_reg == CDLC_SEQ_RUN) && seq_mode;
  wire seq_done   = seq_load && (seq_ch_reg == seq_end);
  // addressed write: codes 110 and 111 are not channels
  wire addr_load  = cap_cs && (cap_sel <= `CDLC_SEL_LAST);

  // sequencer next state; a new start is taken only when idle
  always_comb
  begin
    seq_state_next = seq_state_reg;
    seq_ch_next    = seq_ch_reg;
    case (seq_state_reg)
      CDLC_SEQ_IDLE:
      begin
        if (seq_mode && start_rise)
        begin
          seq_state_next = CDLC_SEQ_RUN;
          seq_ch_next    = seq_first;
        end
      end
      CDLC_SEQ_RUN:
      begin
        if (!seq_mode || seq_done)
          seq_state_next = CDLC_SEQ_IDLE;
        else
          seq_ch_next = load_direction ? seq_ch_reg - 3'h1 : seq_ch_reg + 3'h1;
      end
      default:
        seq_state_next = CDLC_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seq_state_reg  <= CDLC_SEQ_IDLE;
      seq_ch_reg     <= `CDLC_CH_FIRST;
      start_prev_reg <= 1'b0;
      pd_reg         <= 1'b0;
    end
    else
    begin
      seq_state_reg  <= pd_reg ? CDLC_SEQ_IDLE : seq_state_next;
      seq_ch_reg     <= seq_ch_next;
      start_prev_reg <= sequence_start_or_select;
      pd_reg         <= power_down_request;
    end
  end

  // load requests queue through the fifo so a burst of codes is not lost
  wire          wr_valid = !pd_reg && (seq_load || (!seq_mode && addr_load));
  wire cdlc_sel_t wr_ch  = seq_load ? seq_ch_reg : cap_sel;
  wire          wr_ready;
  wire [FW-1:0] rd_data;
  wire          rd_valid;
  logic         xfr_pend_reg;
  // the read side holds still while a transfer is pending, so the staged words do not change
  wire          rd_ready = !xfr_pend_reg;

  cdlc_fifo #(
    .WIDTH (FW),
    .DEPTH (`CDLC_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_data   ({wr_ch, cap_code}),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  // staging drains one word per cycle; transfer holds the drain off so a
  // transfer always moves a consistent set of staged words
  wire  drain = rd_valid && rd_ready;
  wire cdlc_sel_t rd_ch = rd_data[FW-1 -: `CDLC_SEL_W];
  wire cdlc_code_t rd_code = rd_data[`CDLC_CODE_W-1:0];
  cdlc_code_t stage_reg [NUM_CH];

  // first (master) stage: one staged word per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_stage
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          stage_reg[g] <= `CDLC_CODE_RST;
        else if (drain && rd_ch == `CDLC_SEL_W'(g))
          stage_reg[g] <= rd_code;
      end
    end
  endgenerate

  // transfer strobe sampled at the rising edge
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      xfr_pend_reg <= 1'b0;
    else
      xfr_pend_reg <= output_transfer_strobe && !pd_reg;
  end

  // second (slave) stage loads on the following falling edge, all at once
  always_ff @(negedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_code  <= '0;
      // code zero sits a full span away from the midpoint
      dac_level <= {NUM_CH{`CDLC_CODE_FULL}};
    end
    else if (xfr_pend_reg)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        dac_code[i]  <= stage_reg[i];
        // distance from midpoint is full scale times (1 - code/1023)
        dac_level[i] <= `CDLC_CODE_FULL - stage_reg[i];
      end
    end
  end

  // status outputs; overflow is sticky until reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      polarity_above_mid <= 1'b0;
      power_down_active  <= 1'b0;
      load_overflow      <= 1'b0;
    end
    else
    begin
      polarity_above_mid <= polarity_invert;
      power_down_active  <= pd_reg;
      load_overflow      <= load_overflow || (wr_valid && !wr_ready);
    end
  end
endmodule

// File: rtl/cdlc_defines.svh
// constants for the column dac load control block
// assumes inclusion by bare name from the rtl files
`ifndef CDLC_DEFINES_SVH
`define CDLC_DEFINES_SVH
`define CDLC_CODE_W      10
`define CDLC_CODE_MSB    9
`define CDLC_NUM_CH      6
`define CDLC_SEL_W       3
`define CDLC_SEL_SEQ     3'h7
`define CDLC_SEL_NONE    3'h6
`define CDLC_SEL_LAST    3'h5
`define CDLC_CH_FIRST    3'h0
`define CDLC_CH_LAST     3'h5
`define CDLC_CODE_FULL   10'h3FF
`define CDLC_CODE_RST    10'h000
`define CDLC_FIFO_DEPTH  16
`endif

// File: rtl/cdlc_pkg.sv
// types for the column dac load control block
// assumes cdlc_defines.svh is on the include path
`include "cdlc_defines.svh"
package cdlc_pkg;
  typedef logic [`CDLC_CODE_W-1:0] cdlc_code_t;
  typedef logic [`CDLC_SEL_W-1:0]  cdlc_sel_t;
  typedef enum logic [1:0] {CDLC_SEQ_IDLE, CDLC_SEQ_RUN} cdlc_seq_e;
endpackage

// File: rtl/cdlc_fifo.sv
// cdlc_fifo: synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
module cdlc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  // honest flags taken straight from the occupancy count
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset, only the pointers and the count do
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: verification/cdlc_top_asserts.sv
// concurrent checks on the cdlc_top ports
// assumes binding onto cdlc_top, all inputs synchronous to mclk
`timescale 1ns/1ns
`include "cdlc_defines.svh"
module cdlc_top_asserts #(
  parameter int NUM_CH = `CDLC_NUM_CH
) (
  input wire logic                                mclk,
  input wire logic                                rst_b,
  input wire logic                                polarity_invert,
  input wire logic                                power_down_request,
  input wire logic                                output_transfer_strobe,
  input wire logic [NUM_CH-1:0][`CDLC_CODE_W-1:0] dac_code,
  input wire logic [NUM_CH-1:0][`CDLC_CODE_W-1:0] dac_level,
  input wire logic                                polarity_above_mid,
  input wire logic                                power_down_active,
  input wire logic                                load_overflow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // level loads on the same edge as the code; only codes stable since the last clock are judged
  chk_level_ch0: assert property (
    $stable(dac_code) |-> dac_level[0] == 10'h3FF - dac_code[0])
    else $error("level of channel 0 is not full scale minus code");
  chk_level_ch5: assert property (
    $stable(dac_code) |-> dac_level[5] == 10'h3FF - dac_code[5])
    else $error("level of channel 5 is not full scale minus code");
  chk_code_by_strobe: assert property (
    !$stable(dac_code) |-> $past(output_transfer_strobe))
    else $error("dac codes moved without a transfer strobe");
  chk_polarity_delay: assert property (
    polarity_above_mid == $past(polarity_invert))
    else $error("polarity output does not follow invert after one clock");
  chk_standby_delay: assert property (
    power_down_active == $past(power_down_request, 2))
    else $error("power-down active does not follow request after two clocks");
  chk_standby_no_xfer: assert property (
    power_down_request && $past(power_down_request) && $past(power_down_request, 2)
    |=> $stable(dac_code))
    else $error("dac codes moved while powered down");
  chk_overflow_sticky: assert property (
    load_overflow |=> load_overflow)
    else $error("overflow flag cleared without reset");
  chk_reset_clear: assert property (
    $rose(rst_b) |-> dac_code == '0 && dac_level[0] == 10'h3FF
      && !load_overflow && !power_down_active)
    else $error("outputs not clear after reset");
endmodule
bind cdlc_top cdlc_top_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .polarity_invert(polarity_invert),
  .power_down_request(power_down_request), .output_transfer_strobe(output_transfer_strobe),
  .dac_code(dac_code), .dac_level(dac_level), .polarity_above_mid(polarity_above_mid),
  .power_down_active(power_down_active), .load_overflow(load_overflow));

// File: verification/cdlc_ctl_model.sv
// timing controller model driving code, select and start/select
// assumes the bench calls its tasks; released code line shows a new pattern
`timescale 1ns/1ns
module cdlc_ctl_model
  import cdlc_pkg::*;
(
  input  wire logic mclk,
  output cdlc_code_t video_code_in,
  output cdlc_sel_t  channel_select,
  output logic       sequence_start_or_select,
  output logic       edge_phase_select,
  output logic       load_direction
);
  initial
  begin
    video_code_in = 10'h000;
    channel_select = 3'h6;
    sequence_start_or_select = 1'b0;
    edge_phase_select = 1'b1;
    load_direction = 1'b0;
  end
  // word a holds until the fall, word b after it, as in even/odd loading
  task automatic load_addr(input cdlc_sel_t s, input cdlc_code_t a, input cdlc_code_t b);
    @(posedge mclk);
    #1 channel_select = s;
    sequence_start_or_select = 1'b1;
    video_code_in = a;
    @(negedge mclk);
    #1 video_code_in = b;
  endtask
  // start edge, then one code per cycle for the six sequenced loads
  task automatic load_seq(input logic dir, input cdlc_code_t c [6]);
    int k;
    @(posedge mclk);
    #1 channel_select = 3'h7;
    load_direction = dir;
    sequence_start_or_select = 1'b1;
    for (k = 0; k < 6; k++)
    begin
      @(posedge mclk);
      #1 sequence_start_or_select = 1'b0;
      video_code_in = c[k];
    end
  endtask
  // release the select; the code line must not keep the last word
  task automatic idle();
    @(posedge mclk);
    #1 sequence_start_or_select = 1'b0;
    video_code_in = ~video_code_in;
  endtask
endmodule

// File: verification/column_dac_load_control_test.sv
// self-checking bench for cdlc_top with the controller model
// assumes the checker is bound from its own file
`timescale 1ns/1ns
`include "cdlc_defines.svh"
module column_dac_load_control_test
  import cdlc_pkg::*;
;
  logic                              mclk;
  logic                              rst_b;
  logic                              output_transfer_strobe;
  logic                              polarity_invert;
  logic                              power_down_request;
  cdlc_code_t                        video_code_in;
  cdlc_sel_t                         channel_select;
  logic                              sequence_start_or_select;
  logic                              edge_phase_select;
  logic                              load_direction;
  cdlc_code_t [`CDLC_NUM_CH-1:0]     dac_code;
  cdlc_code_t [`CDLC_NUM_CH-1:0]     dac_level;
  logic                              polarity_above_mid;
  logic                              power_down_active;
  logic                              load_overflow;
  cdlc_code_t                        exp_code [6];
  int                                n_errors = 0;
  int                                num_checks = 0;
  cdlc_top #(.NUM_CH(`CDLC_NUM_CH)) DUT (
    .video_code_in(video_code_in), .edge_phase_select(edge_phase_select),
    .load_direction(load_direction), .channel_select(channel_select),
    .sequence_start_or_select(sequence_start_or_select),
    .output_transfer_strobe(output_transfer_strobe), .polarity_invert(polarity_invert),
    .power_down_request(power_down_request), .mclk(mclk), .rst_b(rst_b),
    .dac_code(dac_code), .dac_level(dac_level), .polarity_above_mid(polarity_above_mid),
    .power_down_active(power_down_active), .load_overflow(load_overflow));
  cdlc_ctl_model ctl (
    .mclk(mclk), .video_code_in(video_code_in), .channel_select(channel_select),
    .sequence_start_or_select(sequence_start_or_select),
    .edge_phase_select(edge_phase_select), .load_direction(load_direction));
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  task automatic chk_code(input cdlc_code_t got, input cdlc_code_t exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_code({9'h0, got}, {9'h0, exp});
  endtask
  // strobe after four clocks, once the stage has settled, then judge all channels
  task automatic xfer_check();
    int i;
    repeat (4) @(posedge mclk);
    #1 output_transfer_strobe = 1'b1;
    @(posedge mclk);
    #1 output_transfer_strobe = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    for (i = 0; i < 6; i++)
    begin
      chk_code(dac_code[i], exp_code[i]);
      chk_code(dac_level[i], 10'h3FF - exp_code[i]);
    end
  endtask
  task automatic t_load(input logic ph);
    cdlc_code_t a;
    int i;
    ctl.edge_phase_select = ph;
    for (i = 0; i < 6; i++)
    begin
      a = 10'(10'h201 << i) + 10'(ph);
      exp_code[i] = ph ? ~a : a;
      ctl.load_addr(3'(i), a, ~a);
    end
    ctl.load_addr(3'h6, 10'h155, 10'h155);
    ctl.idle();
    xfer_check();
  endtask
  task automatic t_seq(input logic dir);
    cdlc_code_t c [6];
    int k;
    for (k = 0; k < 6; k++)
    begin
      c[k] = 10'(k * 150 + 9) ^ {9'h0, dir};
      exp_code[dir ? 5 - k : k] = c[k];
    end
    ctl.load_seq(dir, c);
    ctl.idle();
    xfer_check();
  endtask
  // loads and transfers are refused while powered down
  task automatic t_pd();
    // a staged word that differs from the outputs makes a leaked transfer visible
    ctl.load_addr(3'h1, 10'h2C3, 10'h2C3);
    ctl.idle();
    polarity_invert = 1'b1;
    power_down_request = 1'b1;
    @(posedge mclk);
    #1 chk_bit(power_down_active, 1'b0);
    chk_bit(polarity_above_mid, 1'b1);
    @(posedge mclk);
    #1 chk_bit(power_down_active, 1'b1);
    ctl.load_addr(3'h0, 10'h0AA, 10'h0AA);
    ctl.idle();
    xfer_check();
    power_down_request = 1'b0;
    polarity_invert = 1'b0;
    repeat (3) @(posedge mclk);
    exp_code[1] = 10'h2C3;
    #1 xfer_check();
  endtask
  // strobe held high stalls the drain, so the fifo fills and refuses
  task automatic t_ovf();
    int i;
    chk_bit(load_overflow, 1'b0);
    output_transfer_strobe = 1'b1;
    for (i = 0; i < 20; i++)
      ctl.load_addr(3'h1, 10'(i), 10'(i));
    ctl.idle();
    output_transfer_strobe = 1'b0;
    @(posedge mclk);
    #1 chk_bit(load_overflow, 1'b1);
    rst_b = 1'b0;
    #20 chk_bit(load_overflow, 1'b0);
    chk_code(dac_code[1], 10'h000);
    chk_code(dac_level[1], 10'h3FF);
    rst_b = 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog: the tests need well under a thousand clocks
  initial
  begin
    #20000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    rst_b = 1'b0;
    output_transfer_strobe = 1'b0;
    polarity_invert = 1'b0;
    power_down_request = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rst_b = 1'b1;
    t_load(1'b1);
    t_load(1'b0);
    t_seq(1'b0);
    t_seq(1'b1);
    t_pd();
    t_ovf();
    wrap_up();
  end
endmodule
